/* File: include/dma_chctl_cfg.svh */
// Purpose: Offsets, field positions and reset values of the channel-control
//          register slice.
// Assumes: Offsets are byte addresses within the controller window.
// Notes:   Definitions only.
`ifndef DMA_CHCTL_CFG_SVH
`define DMA_CHCTL_CFG_SVH

// ----------------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------------
`define CH_NUM 3
`define ADDR_W 12
`define DATA_W 32

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define OFF_SRC_LO 12'h388
`define OFF_SRC_HI 12'h38c
`define OFF_DST_LO 12'h390
`define OFF_DST_HI 12'h394
`define OFF_CFG_LO 12'h398
`define OFF_CFG_HI 12'h39c
`define OFF_CHEN_LO 12'h3a0
`define OFF_CHEN_HI 12'h3a4
`define OFF_ID_LO 12'h3a8
`define OFF_ID_HI 12'h3ac
`define OFF_TEST_LO 12'h3b0
`define OFF_TEST_HI 12'h3b4

// ----------------------------------------------------------------------
// Fields and values
// ----------------------------------------------------------------------
`define FLAG_MSB 2
`define FLAG_LSB 0
`define GATE_MSB 10
`define GATE_LSB 8
`define CFG_EN_BIT 0
`define TEST_BIT 0
`define REG_RESET 32'h0000_0000
`define FLAG_RESET 3'h0
// Identification words; the values are arbitrary.
`define IDENT_LO_VAL 32'h0000_0000
`define IDENT_HI_VAL 32'h0000_0000

`endif

/* File: include/dma_chctl_pkg.sv */
// Purpose: Types shared by the channel-control register slice.
// Assumes: Nothing beyond the configuration header.
// Notes:   Bus phase states follow a Gray sequence.
package dma_chctl_pkg;

  // Data-phase state of the slave port.
  typedef enum logic [1:0] {
    PH_IDLE = 2'h0,
    PH_WRITE = 2'h1,
    PH_STALL = 2'h3,
    PH_READ = 2'h2
  } bus_phase_e;

  // Register selected by an address.
  typedef enum logic [3:0] {
    SEL_NONE = 4'h0,
    SEL_SRC_LO = 4'h1,
    SEL_SRC_HI = 4'h2,
    SEL_DST_LO = 4'h3,
    SEL_DST_HI = 4'h4,
    SEL_CFG_LO = 4'h5,
    SEL_CFG_HI = 4'h6,
    SEL_CHEN_LO = 4'h7,
    SEL_CHEN_HI = 4'h8,
    SEL_ID_LO = 4'h9,
    SEL_ID_HI = 4'ha,
    SEL_TEST_LO = 4'hb,
    SEL_TEST_HI = 4'hc
  } reg_sel_e;

endpackage : dma_chctl_pkg

/* File: hw/dma_chctl_gate.sv */
// Purpose: Per-channel next-value logic of a gated three-bit flag field.
// Assumes: All inputs are synchronous to the register clock.
// Notes:   Purely combinational; the caller holds the flops.
`timescale 1ns/100ps
`default_nettype none
`include "dma_chctl_cfg.svh"

module dma_chctl_gate (
  // Current field and write data.
  input wire logic [`CH_NUM-1:0] cur_i,
  input wire logic [`CH_NUM-1:0] wdata_i,
  input wire logic [`CH_NUM-1:0] gate_i,
  input wire logic wr_i,
  // Qualifiers.
  input wire logic [`CH_NUM-1:0] allow_i,
  input wire logic [`CH_NUM-1:0] clr_i,
  input wire logic zero_i,
  // Next field value.
  output logic [`CH_NUM-1:0] next_o
);

  // ----------------------------------------------------------------------
  // One slice per channel
  // ----------------------------------------------------------------------
  // A software write beats a same-cycle hardware clear, so a restart
  // written just as the last transfer ends is not lost.
  genvar ch;
  generate
    for (ch = 0; ch < `CH_NUM; ch = ch + 1) begin : g_ch
      wire take;
      assign take = wr_i & gate_i[ch] & allow_i[ch];
      assign next_o[ch] = zero_i ? 1'b0 :
                          take ? wdata_i[ch] :
                          clr_i[ch] ? 1'b0 : cur_i[ch];
    end
  endgenerate

endmodule : dma_chctl_gate
`default_nettype wire

/* File: hw/dma_chctl_regs.sv */
// Purpose: Channel-control registers of a three-channel DMA controller,
//          reached over a zero/one-wait AHB-Lite slave port.
// Assumes: Only word accesses; hsize is not checked.
// Notes:   Unmapped addresses read zero, ignore writes, answer OKAY.
`timescale 1ns/100ps
`default_nettype none
`include "dma_chctl_cfg.svh"

module dma_chctl_regs (
  // Clock and reset.
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // AHB-Lite slave port.
  input wire logic hsel_i,
  input wire logic [`ADDR_W-1:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [`DATA_W-1:0] hwdata_i,
  input wire logic hready_i,
  output logic [`DATA_W-1:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // Transfer engine side.
  input wire logic dma_enable_i,
  input wire logic [`CH_NUM-1:0] xfer_done_i,
  output logic [`CH_NUM-1:0] channel_enable_o,
  output logic [`CH_NUM-1:0] src_last_flag_o,
  output logic [`CH_NUM-1:0] dst_last_flag_o,
  output logic slave_port_test_mode_o
);
  import dma_chctl_pkg::*;

  // ----------------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------------
  function automatic reg_sel_e addr_decode(input logic [`ADDR_W-1:0] a);
    case (a)
      `OFF_SRC_LO: addr_decode = SEL_SRC_LO;
      `OFF_SRC_HI: addr_decode = SEL_SRC_HI;
      `OFF_DST_LO: addr_decode = SEL_DST_LO;
      `OFF_DST_HI: addr_decode = SEL_DST_HI;
      `OFF_CFG_LO: addr_decode = SEL_CFG_LO;
      `OFF_CFG_HI: addr_decode = SEL_CFG_HI;
      `OFF_CHEN_LO: addr_decode = SEL_CHEN_LO;
      `OFF_CHEN_HI: addr_decode = SEL_CHEN_HI;
      `OFF_ID_LO: addr_decode = SEL_ID_LO;
      `OFF_ID_HI: addr_decode = SEL_ID_HI;
      `OFF_TEST_LO: addr_decode = SEL_TEST_LO;
      `OFF_TEST_HI: addr_decode = SEL_TEST_HI;
      default: addr_decode = SEL_NONE;
    endcase
  endfunction : addr_decode

  // Shadow slot of a writable register; slot 3 is also the default.
  function automatic logic [1:0] shadow_slot(input reg_sel_e s);
    case (s)
      SEL_SRC_LO: shadow_slot = 2'h0;
      SEL_DST_LO: shadow_slot = 2'h1;
      SEL_CHEN_LO: shadow_slot = 2'h2;
      default: shadow_slot = 2'h3;
    endcase
  endfunction : shadow_slot

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  bus_phase_e phase_reg, phase_next;
  reg_sel_e sel_reg, addr_sel, rd_sel;
  logic [`CH_NUM-1:0] src_reg, src_next, dst_reg, dst_next;
  logic [`CH_NUM-1:0] chen_reg, chen_next;
  logic cfg_en_reg, test_reg;
  logic [`DATA_W-1:0] hrdata_reg, hrdata_next, rd_word;
  logic hready_reg;
  logic [`DATA_W-1:0] shadow_mem [0:3];

  // ----------------------------------------------------------------------
  // Bus phase tracking
  // ----------------------------------------------------------------------
  // A read right after a write waits one cycle, so it sees the new value
  // instead of a stale copy captured during the write's data phase.
  wire addr_ok = hsel_i & hready_i & htrans_i[1];
  wire wr_fire = (phase_reg == PH_WRITE);
  wire [`CH_NUM-1:0] wgate = hwdata_i[`GATE_MSB:`GATE_LSB];
  wire [`CH_NUM-1:0] wflag = hwdata_i[`FLAG_MSB:`FLAG_LSB];
  assign addr_sel = addr_decode(haddr_i);
  assign rd_sel = (phase_reg == PH_STALL) ? sel_reg : addr_sel;

  always_comb begin
    case (phase_reg)
      PH_STALL: phase_next = PH_READ;
      PH_IDLE, PH_WRITE, PH_READ: begin
        if (!addr_ok) begin
          phase_next = PH_IDLE;
        end else if (hwrite_i) begin
          phase_next = PH_WRITE;
        end else if (phase_reg == PH_WRITE) begin
          phase_next = PH_STALL;
        end else begin
          phase_next = PH_READ;
        end
      end
      default: phase_next = PH_IDLE;
    endcase
  end

  // ----------------------------------------------------------------------
  // Write strobes and field next values
  // ----------------------------------------------------------------------
  wire src_wr = wr_fire & (sel_reg == SEL_SRC_LO);
  wire dst_wr = wr_fire & (sel_reg == SEL_DST_LO);
  wire chen_wr = wr_fire & (sel_reg == SEL_CHEN_LO);
  wire test_wr = wr_fire & (sel_reg == SEL_TEST_LO);
  // Writable registers keep their last word for test-mode readback.
  wire shadow_wr = src_wr | dst_wr | chen_wr | test_wr;

  // Flags need their gate bit and a running channel.
  dma_chctl_gate u_src_gate (
    .cur_i(src_reg),
    .wdata_i(wflag),
    .gate_i(wgate),
    .wr_i(src_wr),
    .allow_i(chen_reg),
    .clr_i(`FLAG_RESET),
    .zero_i(1'b0),
    .next_o(src_next)
  );

  dma_chctl_gate u_dst_gate (
    .cur_i(dst_reg),
    .wdata_i(wflag),
    .gate_i(wgate),
    .wr_i(dst_wr),
    .allow_i(chen_reg),
    .clr_i(`FLAG_RESET),
    .zero_i(1'b0),
    .next_o(dst_next)
  );

  // Enables obey their gate, drop on completion and on global disable.
  dma_chctl_gate u_chen_gate (
    .cur_i(chen_reg),
    .wdata_i(wflag),
    .gate_i(wgate),
    .wr_i(chen_wr),
    .allow_i({`CH_NUM{1'b1}}),
    .clr_i(xfer_done_i),
    .zero_i(~cfg_en_reg),
    .next_o(chen_next)
  );

  // ----------------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------------
  // Outside test mode, write-only gate fields and reserved bits read zero; the global enable
  // and ident words ignore writes in either mode.
  wire test_hit = test_reg & (shadow_slot(rd_sel) != 2'h3 ||
                              rd_sel == SEL_TEST_LO);
  always_comb begin
    rd_word = `REG_RESET;
    if (test_hit) begin
      rd_word = shadow_mem[shadow_slot(rd_sel)];
    end else begin
      case (rd_sel)
        SEL_SRC_LO: rd_word[`FLAG_MSB:`FLAG_LSB] = src_reg;
        SEL_DST_LO: rd_word[`FLAG_MSB:`FLAG_LSB] = dst_reg;
        SEL_CHEN_LO: rd_word[`FLAG_MSB:`FLAG_LSB] = chen_reg;
        SEL_CFG_LO: rd_word[`CFG_EN_BIT] = cfg_en_reg;
        SEL_TEST_LO: rd_word[`TEST_BIT] = test_reg;
        SEL_ID_LO: rd_word = `IDENT_LO_VAL;
        SEL_ID_HI: rd_word = `IDENT_HI_VAL;
        default: rd_word = `REG_RESET;
      endcase
    end
  end
  assign hrdata_next = (phase_next == PH_READ) ? rd_word : `REG_RESET;

  // ----------------------------------------------------------------------
  // Flops
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase_reg <= PH_IDLE;
      sel_reg <= SEL_NONE;
      hready_reg <= 1'b1;
      hrdata_reg <= `REG_RESET;
    end else begin
      phase_reg <= phase_next;
      hready_reg <= (phase_next != PH_STALL);
      hrdata_reg <= hrdata_next;
      if (addr_ok) begin
        sel_reg <= addr_sel;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      src_reg <= `FLAG_RESET;
      dst_reg <= `FLAG_RESET;
      chen_reg <= `FLAG_RESET;
      cfg_en_reg <= 1'b0;
      test_reg <= 1'b0;
    end else begin
      src_reg <= src_next;
      dst_reg <= dst_next;
      chen_reg <= chen_next;
      cfg_en_reg <= dma_enable_i;
      if (test_wr) begin
        test_reg <= hwdata_i[`TEST_BIT];
      end
    end
  end

  // Shadow words hold the whole written word for test readback.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < 4; i++) begin
        shadow_mem[i] <= `REG_RESET;
      end
    end else if (shadow_wr) begin
      shadow_mem[shadow_slot(sel_reg)] <= hwdata_i;
    end
  end

  assign hrdata_o = hrdata_reg;
  assign hreadyout_o = hready_reg;
  assign hresp_o = 1'b0;
  assign channel_enable_o = chen_reg;
  assign src_last_flag_o = src_reg;
  assign dst_last_flag_o = dst_reg;
  assign slave_port_test_mode_o = test_reg;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  wire [`CH_NUM-1:0] src_ok = src_wr ? (wgate & chen_reg) : `FLAG_RESET;
  wire [`CH_NUM-1:0] dst_ok = dst_wr ? (wgate & chen_reg) : `FLAG_RESET;
  wire [`CH_NUM-1:0] chen_ok = chen_wr ? wgate : `FLAG_RESET;

  global_off_a: assert property (!cfg_en_reg |=> chen_reg == 3'h0)
    else $error("channel enable not forced off");
  done_clears_a: assert property (
    (chen_reg & $past(xfer_done_i & ~chen_ok)) == 3'h0)
    else $error("completed channel still enabled");
  src_gated_a: assert property (
    ((src_reg ^ $past(src_reg)) & ~$past(src_ok)) == 3'h0)
    else $error("source flag changed without gate");
  dst_gated_a: assert property (
    ((dst_reg ^ $past(dst_reg)) & ~$past(dst_ok)) == 3'h0)
    else $error("destination flag changed without gate");
  src_value_a: assert property (
    src_ok[0] |=> src_reg[0] == $past(hwdata_i[0]))
    else $error("source flag did not take written value");
  dst_value_a: assert property (
    dst_ok[1] |=> dst_reg[1] == $past(hwdata_i[1]))
    else $error("destination flag did not take written value");
  chen_gated_a: assert property (
    ((chen_reg ^ $past(chen_reg)) &
     ~$past(chen_ok | xfer_done_i | {3{~cfg_en_reg}})) == 3'h0)
    else $error("channel enable changed without cause");
  chen_value_a: assert property (
    cfg_en_reg && chen_ok[2] |=> chen_reg[2] == $past(hwdata_i[2]))
    else $error("channel enable did not take written value");
  test_echo_a: assert property (
    phase_reg == PH_STALL && test_reg && sel_reg == SEL_SRC_LO
    |=> hreadyout_o && hrdata_o == shadow_mem[0])
    else $error("test readback mismatch");
  cfg_ro_a: assert property (
    test_reg && wr_fire && sel_reg == SEL_CFG_LO
    |=> cfg_en_reg == $past(dma_enable_i) && src_reg == $past(src_reg))
    else $error("read-only register took a write");
  hi_zero_a: assert property (
    addr_ok && !hwrite_i && !wr_fire && addr_sel == SEL_CHEN_HI
    |=> hrdata_o == 32'h0000_0000)
    else $error("upper register read not zero");
  stall_once_a: assert property (
    !hreadyout_o |-> ##1 hreadyout_o && phase_reg == PH_READ)
    else $error("wait state longer than one cycle");

endmodule : dma_chctl_regs
`default_nettype wire

/* File: bench/dma_chctl_regs_tb_top.sv */
// Purpose: Self-checking bench for the channel-control register slice.
// Assumes: One AHB-Lite transfer at a time, apart from the pipelined write-read of wr_rd; bus ready loops back from the
//          slave so the address phase is only taken when the slave is free.
// Notes:   Expected values follow the register map, never the outputs.
`timescale 1ns/100ps
`default_nettype none
`include "dma_chctl_cfg.svh"

module dma_chctl_regs_tb_top;
  // ----------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic hsel_i = 1'b0;
  logic [`ADDR_W-1:0] haddr_i = 12'h000;
  logic [1:0] htrans_i = 2'h0;
  logic hwrite_i = 1'b0;
  logic [`DATA_W-1:0] hwdata_i = 32'h0000_0000;
  wire logic hready_i;
  logic [`DATA_W-1:0] hrdata_o;
  logic hreadyout_o;
  logic hresp_o;
  logic dma_enable_i = 1'b0;
  logic [`CH_NUM-1:0] xfer_done_i = 3'h0;
  logic [`CH_NUM-1:0] channel_enable_o;
  logic [`CH_NUM-1:0] src_last_flag_o;
  logic [`CH_NUM-1:0] dst_last_flag_o;
  logic slave_port_test_mode_o;
  int error_cnt = 0;
  int checked = 0;
  int cyc = 0;
  logic [31:0] rdat;

  // Single slave on the bus, so its own ready is the bus ready.
  assign hready_i = hreadyout_o;

  always #5 ref_clk_i = ~ref_clk_i;

  dma_chctl_regs u_dma_chctl_regs (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .hsel_i(hsel_i),
    .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
    .hwdata_i(hwdata_i), .hready_i(hready_i), .hrdata_o(hrdata_o),
    .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .dma_enable_i(dma_enable_i), .xfer_done_i(xfer_done_i),
    .channel_enable_o(channel_enable_o), .src_last_flag_o(src_last_flag_o),
    .dst_last_flag_o(dst_last_flag_o),
    .slave_port_test_mode_o(slave_port_test_mode_o)
  );

  // ----------------------------------------------------------------------
  // Reporting
  // ----------------------------------------------------------------------
  task automatic close_out();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : close_out

  // The run is about 150 cycles; a hang past this ceiling is a fault.
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      error_cnt++;
      $display("[ERR] t=%0t timeout got %h exp %h", $time, cyc, 0);
      close_out();
    end
  end

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t word got %h exp %h", $time, got, exp);
    end
  endtask : chk32

  task automatic chk3(input logic [2:0] got, input logic [2:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t bits got %h exp %h", $time, got, exp);
    end
  endtask : chk3

  task automatic test_end(input string name);
    $display("test %s done, checks %0d mismatches %0d", name, checked,
             error_cnt);
  endtask : test_end

  // ----------------------------------------------------------------------
  // Bus access
  // ----------------------------------------------------------------------
  // Ready and read data are looked at on the rising edge itself, before
  // the slave's flops update, so each phase ends where the slave sees it.
  task automatic bus(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge ref_clk_i);
    #1;
    hsel_i = 1'b1;
    htrans_i = 2'h2;
    hwrite_i = wr;
    haddr_i = a;
    @(posedge ref_clk_i);
    while (hreadyout_o !== 1'b1) @(posedge ref_clk_i);
    #1;
    hsel_i = 1'b0;
    htrans_i = 2'h0;
    haddr_i = ~a;
    hwdata_i = d;
    @(posedge ref_clk_i);
    while (hreadyout_o !== 1'b1) @(posedge ref_clk_i);
    q = hrdata_o;
    #1;
    hwdata_i = ~d;
  endtask : bus

  // Pipelined write then read: the read address rides in the write's data
  // phase, which is the only path that makes the slave insert a wait.
  task automatic wr_rd(input logic [11:0] wa, input logic [31:0] d,
                       input logic [11:0] ra, input logic [31:0] exp);
    @(posedge ref_clk_i);
    #1;
    hsel_i = 1'b1;
    htrans_i = 2'h2;
    hwrite_i = 1'b1;
    haddr_i = wa;
    @(posedge ref_clk_i);
    while (hreadyout_o !== 1'b1) @(posedge ref_clk_i);
    #1;
    hwrite_i = 1'b0;
    haddr_i = ra;
    hwdata_i = d;
    @(posedge ref_clk_i);
    while (hreadyout_o !== 1'b1) @(posedge ref_clk_i);
    #1;
    hsel_i = 1'b0;
    htrans_i = 2'h0;
    haddr_i = ~ra;
    hwdata_i = ~d;
    @(posedge ref_clk_i);
    while (hreadyout_o !== 1'b1) @(posedge ref_clk_i);
    chk32(hrdata_o, exp);
    #1;
  endtask : wr_rd

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, q);
    chk32(q, exp);
  endtask : rd_chk

  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask : idle

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    idle(4);
    rst_n_i = 1'b1;
    // Every register, including upper halves and gaps, starts at zero.
    for (int i = 0; i < 12; i++) begin
      rd_chk(12'h388 + 12'(4 * i), `REG_RESET);
    end
    rd_chk(12'h100, 32'h0000_0000);
    chk32({31'h0, hresp_o}, 32'h0000_0000);
    test_end("reset");

    dma_enable_i = 1'b1;
    idle(2);
    rd_chk(`OFF_CFG_LO, 32'h0000_0001);
    wr(`OFF_CFG_LO, 32'h0000_0000);
    rd_chk(`OFF_CFG_LO, 32'h0000_0001);
    // Gate ch0 and ch1 only; the ungated ch2 data bit must be dropped.
    wr(`OFF_CHEN_LO, 32'h0000_0307);
    chk3(channel_enable_o, 3'h3);
    rd_chk(`OFF_CHEN_LO, 32'h0000_0003);
    wr(`OFF_CHEN_LO, 32'h0000_0004);
    chk3(channel_enable_o, 3'h3);
    // Gated ch2 is switched on and off again; ch0 and ch1 stay as they are.
    wr(`OFF_CHEN_LO, 32'h0000_0404);
    chk3(channel_enable_o, 3'h7);
    wr(`OFF_CHEN_LO, 32'h0000_0400);
    chk3(channel_enable_o, 3'h3);
    wr(`OFF_CHEN_HI, 32'hffff_ffff);
    rd_chk(`OFF_CHEN_HI, 32'h0000_0000);
    test_end("enable");

    // Ch2 is disabled, so its flag stays clear despite its gate.
    wr(`OFF_SRC_LO, 32'h0000_0707);
    chk3(src_last_flag_o, 3'h3);
    rd_chk(`OFF_SRC_LO, 32'h0000_0003);
    wr(`OFF_SRC_LO, 32'h0000_0106);
    chk3(src_last_flag_o, 3'h2);
    wr(`OFF_SRC_LO, 32'h0000_0001);
    chk3(src_last_flag_o, 3'h2);
    wr(`OFF_DST_LO, 32'h0000_0607);
    chk3(dst_last_flag_o, 3'h2);
    rd_chk(`OFF_DST_LO, 32'h0000_0002);
    wr(`OFF_DST_LO, 32'h0000_0200);
    chk3(dst_last_flag_o, 3'h0);
    // A read in the write's data phase waits one cycle and sees the new flag.
    wr_rd(`OFF_DST_LO, 32'h0000_0202, `OFF_DST_LO, 32'h0000_0002);
    test_end("last_flags");

    // Completion on ch1, plus one on the already idle ch2.
    xfer_done_i = 3'h6;
    @(posedge ref_clk_i);
    #1;
    xfer_done_i = 3'h0;
    chk3(channel_enable_o, 3'h1);
    rd_chk(`OFF_CHEN_LO, 32'h0000_0001);
    test_end("auto_clear");

    dma_enable_i = 1'b0;
    idle(3);
    chk3(channel_enable_o, 3'h0);
    wr(`OFF_CHEN_LO, 32'h0000_0707);
    chk3(channel_enable_o, 3'h0);
    rd_chk(`OFF_CFG_LO, 32'h0000_0000);
    test_end("global_off");

    dma_enable_i = 1'b1;
    wr(`OFF_TEST_LO, 32'h0000_0001);
    chk3({2'h0, slave_port_test_mode_o}, 3'h1);
    rd_chk(`OFF_TEST_LO, 32'h0000_0001);
    wr(`OFF_SRC_LO, 32'ha5a5_0505);
    rd_chk(`OFF_SRC_LO, 32'ha5a5_0505);
    wr_rd(`OFF_SRC_LO, 32'h5a5a_0000, `OFF_SRC_LO, 32'h5a5a_0000);
    wr(`OFF_CFG_LO, 32'hffff_fff0);
    rd_chk(`OFF_CFG_LO, 32'h0000_0001);
    wr(`OFF_ID_LO, 32'hffff_ffff);
    rd_chk(`OFF_ID_LO, `IDENT_LO_VAL);
    wr(`OFF_SRC_HI, 32'hffff_ffff);
    rd_chk(`OFF_SRC_HI, 32'h0000_0000);
    // All channels are off, so the test-mode word left the flags alone.
    wr(`OFF_TEST_LO, 32'h0000_0000);
    rd_chk(`OFF_SRC_LO, 32'h0000_0002);
    chk3({2'h0, slave_port_test_mode_o}, 3'h0);
    test_end("test_mode");

    close_out();
  end
endmodule : dma_chctl_regs_tb_top
`default_nettype wire
